// *** eeprom_target_front.sv ***
// target front end: start/stop, bit framing, acknowledge and address decode
// assumes start and stop setup times of at least two system clock periods
`timescale 1ns/1ps
`default_nettype none

module eeprom_target_front (
    input  wire logic                        clk,                     // 200 MHz system clock
    input  wire logic                        resetn,                  // sync reset, active low
    input  wire logic                        scl_link,                // bus clock pin
    input  wire logic                        sda_in,                  // bus data pin level
    output logic                             sda_out,                 // data drive value, always low
    output logic                             sda_oe_n,                // low while pulling data low
    input  wire logic [7:0]                  address_config_register, // chip enables in bits 3..1
    input  wire logic                        idpage_locked,           // identification page locked
    input  wire logic                        write_busy,              // internal write cycle running
    output logic                             write_start,             // one-cycle write launch
    output logic                             standby,                 // device in standby
    output logic                             rw_dir,                  // one read, zero write
    output eeprom_front_pkg::target_t        target,                  // decoded access target
    output logic [15:0]                      mem_addr,                // array address
    output logic [eeprom_front_pkg::IDPAGE_AW-1:0] idpage_offset,     // identification page offset
    output logic [7:0]                       rx_data,                 // received write data byte
    output logic                             rx_valid,                // data byte available
    input  wire logic                        rx_ready                 // consumer takes byte
);
    import eeprom_front_pkg::*;

    // ----------------------------------------------------------------
    // feature decode
    // ----------------------------------------------------------------
    function automatic target_t feat_decode(input logic [2:0] code);
        target_t t;
        t = TGT_NONE;
        unique case (code)
            FEAT_ID:     t = TGT_ID;
            FEAT_CFG:    t = TGT_CFG;
            FEAT_WPROT:  t = TGT_WPROT;
            FEAT_IDPAGE: t = TGT_IDPAGE;
            FEAT_LOCK:   t = TGT_LOCK;
            default:     t = TGT_NONE;
        endcase
        return t;
    endfunction

    // ----------------------------------------------------------------
    // pin synchronisers and link crossing
    // ----------------------------------------------------------------
    logic       scl_s1_r, scl_s2_r, scl_s3_r;   // clock pin sync and history
    logic       sda_s1_r, sda_s2_r, sda_s3_r;   // data pin sync and history
    logic       bit_val;                        // link domain bit, stable from one rise to the next

    // rises are seen through the clock pin synchroniser, not the toggle,
    // so a link clock that stands still across reset loses no bit
    link_bit_capture link_bit_capture_inst (
        .scl_link (scl_link),
        .resetn   (resetn),
        .sda_in   (sda_in),
        .bit_tgl  (),
        .bit_val  (bit_val)
    );

    // two flops per pin, third for edges
    always_ff @(posedge clk) begin
        scl_s1_r <= scl_link;
        scl_s2_r <= scl_s1_r;
        scl_s3_r <= scl_s2_r;
        sda_s1_r <= sda_in;
        sda_s2_r <= sda_s1_r;
        sda_s3_r <= sda_s2_r;
    end

    wire scl_high = scl_s2_r && scl_s3_r;              // clock stable high
    wire start_det = scl_high && sda_s3_r && !sda_s2_r;
    wire stop_det  = scl_high && !sda_s3_r && sda_s2_r;
    wire scl_fall  = scl_s3_r && !scl_s2_r;            // clock falling edge
    // link bit has settled well before the synchronised rise shows here
    wire bit_evt   = scl_s2_r && !scl_s3_r;            // one captured bit

    // ----------------------------------------------------------------
    // framing state
    // ----------------------------------------------------------------
    state_t     state_r, state_nxt;     // protocol state
    logic [3:0] cnt_r;                  // bit index within frame
    logic [6:0] shift_r;                // bits received so far
    logic       ack_pend_r;             // acknowledge to drive at next fall
    logic       write_arm_r;            // data byte acked, stop may launch
    logic       read_nack_r;            // controller refused a read byte
    logic       ack_nxt;                // acknowledge decision
    logic       push_nxt;               // data byte into buffer
    logic       buf_ready;              // buffer has room
    target_t    target_nxt;             // decoded target

    wire [7:0]  byte_nxt  = {shift_r, bit_val};
    wire        byte_done = bit_evt && (cnt_r == BIT_LAST);
    wire        ack_slot  = bit_evt && (cnt_r == BIT_ACK);
    wire        ce_match  = byte_nxt[SEL_CE_LSB +: CE_W] == address_config_register[CFG_CE_LSB +: CE_W];
    wire [3:0]  sel_type  = byte_nxt[SEL_TYPE_LSB +: 4];
    wire        type_ok   = (sel_type == TYPE_ARRAY) || (sel_type == TYPE_FEATURE);
    wire        sel_ok    = ce_match && type_ok;
    wire [2:0]  feat_code = byte_nxt[FEAT_LSB +: 3];
    wire        data_ok   = buf_ready && !(target == TGT_IDPAGE && idpage_locked);

    // decision on each completed byte
    always_comb begin
        state_nxt  = state_r;
        ack_nxt    = 1'b0;
        push_nxt   = 1'b0;
        target_nxt = target;
        if (byte_done) begin
            unique case (state_r)
                ST_SEL: begin
                    ack_nxt    = sel_ok;
                    state_nxt  = !sel_ok ? ST_IGNORE : (byte_nxt[0] ? ST_READ : ST_ADDR_HI);
                    target_nxt = (sel_type == TYPE_ARRAY) ? TGT_ARRAY : TGT_NONE;
                end
                ST_ADDR_HI: begin
                    target_nxt = (target == TGT_ARRAY) ? TGT_ARRAY : feat_decode(feat_code);
                    ack_nxt    = (target_nxt != TGT_NONE);
                    state_nxt  = ack_nxt ? ST_ADDR_LO : ST_IGNORE;
                end
                ST_ADDR_LO: begin
                    ack_nxt   = 1'b1;
                    state_nxt = ST_DATA_W;
                end
                ST_DATA_W: begin
                    ack_nxt  = data_ok;
                    push_nxt = data_ok;
                end
                default: begin
                    ack_nxt = 1'b0;
                end
            endcase
        end
    end

    // state, with stop and a start outside a write cycle taking priority
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_r <= ST_IDLE;
        end else if (start_det && !write_busy) begin
            state_r <= ST_SEL;
        end else if (stop_det) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn || start_det) begin
            cnt_r   <= '0;
            shift_r <= '0;
        end else if (bit_evt) begin
            cnt_r   <= (cnt_r == BIT_ACK) ? 4'h0 : cnt_r + 4'h1;
            if (cnt_r != BIT_ACK) shift_r <= byte_nxt[6:0];
        end
    end

    // ----------------------------------------------------------------
    // acknowledge drive
    // ----------------------------------------------------------------
    // pull low for ninth clock
    always_ff @(posedge clk) begin
        if (!resetn || start_det || stop_det) begin
            ack_pend_r <= 1'b0;
            sda_oe_n   <= 1'b1;
        end else begin
            if (byte_done) ack_pend_r <= ack_nxt;
            else if (scl_fall && ack_pend_r) ack_pend_r <= 1'b0;
            if (scl_fall && ack_pend_r) sda_oe_n <= 1'b0;
            else if (scl_fall && cnt_r == 4'h0) sda_oe_n <= 1'b1;
        end
    end
    assign sda_out = 1'b0;   // only ever pulls low, never drives high

    // ----------------------------------------------------------------
    // write launch, standby, read refusal
    // ----------------------------------------------------------------
    // stop right after acked data byte
    always_ff @(posedge clk) begin
        if (!resetn || start_det) begin
            write_arm_r <= 1'b0;
        end else if (push_nxt) begin
            write_arm_r <= 1'b1;
        end else if (bit_evt && cnt_r == BIT_ARM_END) begin
            write_arm_r <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            write_start <= 1'b0;
        end else begin
            write_start <= stop_det && write_arm_r && (state_r == ST_DATA_W);
        end
    end

    // refused read then stop gives standby
    always_ff @(posedge clk) begin
        if (!resetn || start_det) begin
            read_nack_r <= 1'b0;
        end else if (ack_slot && state_r == ST_READ && bit_val) begin
            read_nack_r <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            standby <= 1'b1;
        end else if (start_det && !write_busy) begin
            standby <= 1'b0;
        end else if (stop_det || (byte_done && state_nxt == ST_IGNORE)) begin
            standby <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // decoded address outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rw_dir        <= 1'b0;
            target        <= TGT_NONE;
            mem_addr      <= '0;
            idpage_offset <= '0;
        end else if (byte_done) begin
            target <= target_nxt;
            if (state_r == ST_SEL) rw_dir <= byte_nxt[0];
            if (state_r == ST_ADDR_HI) mem_addr[15:8] <= byte_nxt;
            if (state_r == ST_ADDR_LO) mem_addr[7:0]  <= byte_nxt;
            if (state_r == ST_ADDR_LO) idpage_offset <= byte_nxt[IDPAGE_AW-1:0];
        end
    end

    // ----------------------------------------------------------------
    // data byte buffer
    // ----------------------------------------------------------------
    byte_buffer #(
        .WIDTH (8),
        .DEPTH (2)
    ) byte_buffer_inst (
        .clk     (clk),
        .resetn  (resetn),
        .s_valid (push_nxt),
        .s_ready (buf_ready),
        .s_data  (byte_nxt),
        .m_valid (rx_valid),
        .m_ready (rx_ready),
        .m_data  (rx_data)
    );

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence ack_armed_s;
        byte_done && ack_nxt;
    endsequence
    sequence ack_driven_s;
        ##[1:40] (scl_fall && ack_pend_r) ##1 !sda_oe_n;
    endsequence

    start_to_select_a: assert property (start_det && !write_busy |=> state_r == ST_SEL)
        else $error("start did not open select");
    busy_ignore_a: assert property (start_det && write_busy && state_r == ST_IDLE |=> state_r == ST_IDLE)
        else $error("start taken during write cycle");
    stop_standby_a: assert property (stop_det |=> standby && state_r == ST_IDLE)
        else $error("stop did not end communication");
    write_launch_a: assert property (stop_det && write_arm_r && state_r == ST_DATA_W |=> write_start)
        else $error("write cycle not launched");
    bit_count_a: assert property (bit_evt && !start_det && cnt_r == 4'h3 |=> cnt_r == 4'h4)
        else $error("bit index did not advance");
    ack_drive_a: assert property (ack_armed_s |-> ack_driven_s)
        else $error("acknowledge not driven");
    mismatch_drop_a: assert property (byte_done && state_r == ST_SEL && !ce_match && !start_det && !stop_det
                                      |=> state_r == ST_IGNORE && !ack_pend_r)
        else $error("mismatched select not dropped");
    rw_capture_a: assert property (byte_done && state_r == ST_SEL |=> rw_dir == $past(bit_val))
        else $error("direction bit not captured");
    feat_decode_a: assert property (byte_done && state_r == ST_ADDR_HI && target == TGT_NONE && feat_code == FEAT_ID
                                    |=> target == TGT_ID)
        else $error("identifier target not decoded");
    locked_nack_a: assert property (byte_done && state_r == ST_DATA_W && target == TGT_IDPAGE && idpage_locked
                                    |=> !ack_pend_r)
        else $error("locked page data acknowledged");
    ignore_quiet_a: assert property (state_r == ST_IGNORE && !ack_pend_r |=> sda_oe_n)
        else $error("deselected device drives data");
    read_nack_standby_a: assert property (stop_det && read_nack_r |=> standby)
        else $error("refused read not followed by standby");

endmodule // eeprom_target_front

`default_nettype wire

// *** eeprom_front_pkg.sv ***
// constants, states and targets shared by the two-wire target front end
// assumes a single 200 MHz system clock and a link clock taken from the bus clock pin
// Functional notes
// - device is only ever a bus target
// - start is data falling while clock high
// - starts ignored while internal write cycle runs
// - stop is data rising while clock high
// - stop after read not-acknowledge enters standby
// - stop closing a write launches write cycle
// - data bits captured on clock rising edge
// - receiver pulls data low in ninth bit
// - select bits 3..1 compared with chip enables
// - match acknowledges, mismatch releases and stands by
// - select bit 0: one read, zero write
// - select and address bytes arrive msb first
// - type 1010 array, type 1011 features
// - select byte type picks array or feature, first address byte bits 7..5 pick the feature
// - identification page offset from bits 6..0
// - locked identification page refuses write data
`default_nettype none
package eeprom_front_pkg;

    // ----------------------------------------------------------------
    // select byte layout
    // ----------------------------------------------------------------
    localparam logic [3:0] TYPE_ARRAY   = 4'ha;   // memory array type code
    localparam logic [3:0] TYPE_FEATURE = 4'hb;   // feature space type code
    localparam int         SEL_TYPE_LSB = 4;      // type code position
    localparam int         SEL_CE_LSB   = 1;      // chip enable field position
    localparam int         CFG_CE_LSB   = 1;      // chip enables in address config register
    localparam int         CE_W         = 3;      // chip enable width

    // ----------------------------------------------------------------
    // first address byte feature codes (bits 7..5)
    // ----------------------------------------------------------------
    localparam logic [2:0] FEAT_ID      = 3'h7;   // type identifier register
    localparam logic [2:0] FEAT_CFG     = 3'h6;   // address configuration register
    localparam logic [2:0] FEAT_WPROT   = 3'h5;   // write protect register
    localparam logic [2:0] FEAT_IDPAGE  = 3'h0;   // identification page
    localparam logic [2:0] FEAT_LOCK    = 3'h3;   // identification page lock
    localparam int         FEAT_LSB     = 5;      // feature code position
    localparam int         IDPAGE_AW    = 7;      // 128 byte page offset width

    // ----------------------------------------------------------------
    // framing
    // ----------------------------------------------------------------
    localparam logic [3:0] BIT_LAST     = 4'h7;   // eighth data bit index
    localparam logic [3:0] BIT_ACK      = 4'h8;   // ninth bit index
    localparam logic [3:0] BIT_ARM_END  = 4'h1;   // last count that still may close a write

    typedef enum logic [2:0] {
        ST_IDLE, ST_SEL, ST_ADDR_HI, ST_ADDR_LO, ST_DATA_W, ST_READ, ST_IGNORE
    } state_t;

    typedef enum logic [2:0] {
        TGT_ARRAY, TGT_ID, TGT_CFG, TGT_WPROT, TGT_IDPAGE, TGT_LOCK, TGT_NONE
    } target_t;

endpackage
`default_nettype wire

// *** eeprom_front_helpers.sv ***
// link-side bit capture and the two-entry byte buffer
// assumes the link clock is the bus clock pin and may stop between frames
`timescale 1ns/1ps
`default_nettype none

// --------------------------------------------------------------------
// bit capture on the link clock
// --------------------------------------------------------------------
module link_bit_capture (
    input  wire logic scl_link,   // bus clock pin used as clock
    input  wire logic resetn,     // system reset, active low
    input  wire logic sda_in,     // bus data pin
    output logic      bit_tgl,    // flips once per captured bit
    output logic      bit_val     // last captured bit, held until next edge
);
    logic rst_s1_r;   // reset synchroniser first stage
    logic rst_s2_r;   // reset synchroniser second stage

    // reset brought into the link domain
    always_ff @(posedge scl_link) begin
        rst_s1_r <= resetn;
        rst_s2_r <= rst_s1_r;
    end

    // sample on rising edge
    // no reset: a stopped link clock would otherwise hold the first bits of a frame
    always_ff @(posedge scl_link) begin
        bit_val <= sda_in;
    end

    // edge toggle, cleared while the link stage is held in reset
    always_ff @(posedge scl_link) begin
        if (!rst_s2_r) begin
            bit_tgl <= 1'b0;
        end else begin
            bit_tgl <= ~bit_tgl;
        end
    end
endmodule // link_bit_capture

// --------------------------------------------------------------------
// small fifo between receiver and user side
// --------------------------------------------------------------------
module byte_buffer #(
    parameter int WIDTH = 8,      // word width
    parameter int DEPTH = 2       // entries, power of two
) (
    input  wire logic             clk,      // system clock
    input  wire logic             resetn,   // sync reset, active low
    input  wire logic             s_valid,  // push request
    output logic                  s_ready,  // room for a word
    input  wire logic [WIDTH-1:0] s_data,   // pushed word
    output logic                  m_valid,  // word available
    input  wire logic             m_ready,  // consumer takes word
    output logic      [WIDTH-1:0] m_data    // head word
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_r [DEPTH];   // storage
    logic [AW-1:0]    wr_r;            // write pointer
    logic [AW-1:0]    rd_r;            // read pointer
    logic [AW:0]      cnt_r;           // fill level
    wire              push = s_valid && s_ready;   // word accepted
    wire              pop  = m_valid && m_ready;   // word drained

    assign s_ready = (cnt_r != (AW+1)'(DEPTH));
    assign m_valid = (cnt_r != '0);
    assign m_data  = mem_r[rd_r];

    // pointers and level
    always_ff @(posedge clk) begin
        if (!resetn) begin
            wr_r  <= '0;
            rd_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (push) wr_r <= wr_r + 1'b1;
            if (pop)  rd_r <= rd_r + 1'b1;
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // storage write
    always_ff @(posedge clk) begin
        if (push) mem_r[wr_r] <= s_data;
    end
endmodule // byte_buffer

`default_nettype wire

// *** i2c_ctl_model.sv ***
// bus controller model: start, stop and bytes with ninth-bit acknowledge
// assumes a pull-up on the data wire; clock stands high between frames
`timescale 1ns/1ps
`default_nettype none
module i2c_ctl_model (
    output logic      scl,     // bus clock, driven only here
    output logic      sda_drv, // zero pulls data low
    input  wire logic sda      // resolved data wire
);
    localparam time HALF = 24ns; // 48 ns bus clock
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic start();
        sda_drv = 1'b1;
        #HALF scl = 1'b1;
        #HALF sda_drv = 1'b0;
        #HALF scl = 1'b0;
    endtask
    task automatic stop();
        sda_drv = 1'b0;
        #HALF scl = 1'b1;
        #HALF sda_drv = 1'b1;
        #HALF;
    endtask
    // msb first, data moves only while clock low; release in ninth bit
    task automatic send(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sda_drv = b[i];
            #HALF scl = 1'b1;
            #HALF scl = 1'b0;
        end
        sda_drv = 1'b1;
        #HALF scl = 1'b1;
        #HALF ack = (sda === 1'b0);
        scl = 1'b0;
    endtask
endmodule // i2c_ctl_model
`default_nettype wire

// *** eeprom_target_front_test.sv ***
// bench for the target front end, bus controller model on the far side
// assumes open-drain data wire with pull-up
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin num_errors++; \
 $display("wrong value at %0t: got %h expected %h", $time, a, e); end end
module eeprom_target_front_test;
    import eeprom_front_pkg::*;
    logic clk = 0, resetn = 0, locked = 0, busy = 0, rx_ready = 0; // bench driven
    logic [7:0] cfg = 8'h0a;   // chip enables 101
    wire logic scl, ctl_sda, sda, sda_out, sda_oe_n, write_start, standby, rw_dir, rx_valid;
    target_t target;           // decoded target
    logic [15:0] mem_addr;     // array address
    logic [6:0] idpage_offset; // page offset
    logic [7:0] rx_data;       // buffer head
    int num_errors = 0, total_checks = 0, ws_cnt = 0;
    always #2.5 clk = ~clk;
    always @(posedge clk) if (write_start === 1'b1) ws_cnt++;
    assign sda = ctl_sda & (sda_oe_n | sda_out);
    i2c_ctl_model i2c_ctl_model_inst (.scl(scl), .sda_drv(ctl_sda), .sda(sda));
    eeprom_target_front eeprom_target_front_inst (.clk(clk), .resetn(resetn), .scl_link(scl),
        .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .address_config_register(cfg),
        .idpage_locked(locked), .write_busy(busy), .write_start(write_start), .standby(standby),
        .rw_dir(rw_dir), .target(target), .mem_addr(mem_addr), .idpage_offset(idpage_offset),
        .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready));
    // one byte, acknowledge compared
    task automatic put(input logic [7:0] b, input logic exp);
        logic ack;
        i2c_ctl_model_inst.send(b, ack);
        `CHK(ack, exp)
    endtask
    task automatic stp();
        i2c_ctl_model_inst.stop();
        repeat (10) @(negedge clk);
    endtask
    // pop head after comparing it
    task automatic pop(input logic [7:0] e);
        `CHK(rx_data, e)
        rx_ready = 1'b1;
        @(negedge clk) rx_ready = 1'b0;
        @(negedge clk);
    endtask
    task automatic t_write();
        i2c_ctl_model_inst.start();
        put(8'haa, 1'b1);
        put(8'h12, 1'b1);
        put(8'h34, 1'b1);
        put(8'h5a, 1'b1);
        stp();
        `CHK(mem_addr, 16'h1234)
        `CHK(target, TGT_ARRAY)
        `CHK(rw_dir, 1'b0)
        `CHK(ws_cnt, 1)
        `CHK(standby, 1'b1)
        pop(8'h5a);
        $display("test write done");
    endtask
    task automatic t_deselect();
        i2c_ctl_model_inst.start();
        put(8'ha2, 1'b0);
        put(8'h00, 1'b0);
        stp();
        `CHK(standby, 1'b1)
        i2c_ctl_model_inst.start();
        put(8'h9a, 1'b0);
        stp();
        cfg = 8'h04;   // chip enables 010
        i2c_ctl_model_inst.start();
        put(8'ha4, 1'b1);
        `CHK(standby, 1'b0)
        stp();
        cfg = 8'h0a;
        $display("test deselect done");
    endtask
    task automatic t_features();
        logic [2:0] code [5] = '{FEAT_ID, FEAT_CFG, FEAT_WPROT, FEAT_IDPAGE, FEAT_LOCK};
        target_t tg [5] = '{TGT_ID, TGT_CFG, TGT_WPROT, TGT_IDPAGE, TGT_LOCK};
        for (int i = 0; i < 5; i++) begin
            i2c_ctl_model_inst.start();
            put(8'hba, 1'b1);
            put({code[i], 5'h1f}, 1'b1);
            put(8'ha5, 1'b1);
            stp();
            `CHK(target, tg[i])
        end
        `CHK(idpage_offset, 7'h25)
        `CHK(ws_cnt, 1)
        $display("test features done");
    endtask
    task automatic t_lock();
        locked = 1'b1;
        i2c_ctl_model_inst.start();
        put(8'hba, 1'b1);
        put(8'h00, 1'b1);
        put(8'h05, 1'b1);
        put(8'h77, 1'b0);
        stp();
        `CHK(rx_valid, 1'b0)
        locked = 1'b0;
        $display("test lock done");
    endtask
    task automatic t_full();
        i2c_ctl_model_inst.start();
        put(8'haa, 1'b1);
        put(8'h00, 1'b1);
        put(8'h00, 1'b1);
        put(8'h11, 1'b1);
        put(8'h22, 1'b1);
        put(8'h33, 1'b0);
        stp();
        pop(8'h11);
        pop(8'h22);
        `CHK(rx_valid, 1'b0)
        $display("test buffer done");
    endtask
    task automatic t_busy_read();
        busy = 1'b1;
        i2c_ctl_model_inst.start();
        put(8'haa, 1'b0);
        stp();
        busy = 1'b0;
        i2c_ctl_model_inst.start();
        put(8'hab, 1'b1);
        `CHK(rw_dir, 1'b1)
        put(8'hff, 1'b0);
        stp();
        `CHK(standby, 1'b1)
        $display("test busy and read done");
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (10) @(negedge clk);
        resetn = 1'b1;
        repeat (5) @(negedge clk);
        t_write();
        t_deselect();
        t_features();
        t_lock();
        t_full();
        t_busy_read();
        stop_test();
    end
    initial begin
        #200us;
        num_errors++;
        stop_test();
    end
endmodule // eeprom_target_front_test
`default_nettype wire
